// ===== fcs_defs.svh
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

`define FCS_CMD_NULL       4'h0
`define FCS_CMD_READ       4'h1
`define FCS_CMD_WRITE      4'h2
`define FCS_CMD_ERASE_WR   4'h3
`define FCS_CMD_VERIFY     4'h4
`define FCS_CMD_PAGE_ERASE 4'h5
`define FCS_CMD_MASS_ERASE 4'h6
`define FCS_CMD_DONE_CODE  4'h7
`define FCS_CMD_SIGNATURE  4'hb
`define FCS_CMD_PROTECT    4'hc
`define FCS_CMD_PING       4'hf

`define FCS_STA_COMPLETE   0
`define FCS_STA_FAIL       1
`define FCS_STA_BUSY       2
`define FCS_STA_IRQ        3
`define FCS_MOD_WR_EN      3
`define FCS_MOD_IRQ_EN     4

`define FCS_CLK_HZ         20000000
`define FCS_WRITE_NS       50000
`define FCS_ERASE_WR_US    20000
`define FCS_MASS_ERASE_MS  2480
`define FCS_SIGN_CYCLES    32778
`define FCS_KERNEL_WORDS   1024
`define FCS_MASS_KEY       8'h3c

`endif

// ===== fcs_pkg.sv
package fcs_pkg;

  typedef enum logic [4:0] {
    FCS_IDLE  = 5'b00001,
    FCS_ARRAY = 5'b00010,
    FCS_WAIT  = 5'b00100,
    FCS_SIGN  = 5'b01000,
    FCS_DONE  = 5'b10000
  } fcs_state_e;

  typedef struct packed {
    logic        wr_en;
    logic [3:0]  code;
    logic [15:0] addr;
    logic [15:0] data;
  } fcs_cmd_s;

  typedef struct packed {
    logic        req;
    logic        write;
    logic        erase_page;
    logic        erase_mass;
    logic [15:0] addr;
    logic [15:0] wdata;
  } fcs_array_s;

  typedef struct packed {
    fcs_state_e  state;
    logic [3:0]  cmd_code;
    logic [3:0]  cmd_read;
    logic [15:0] data;
    logic [4:0]  status;
    logic [23:0] sign;
    logic [31:0] prot;
    logic        prot_locked;
    logic        prot_done;
    logic [7:0]  mass_key;
    logic [31:0] timer;
    logic        fail;
    fcs_array_s  arr;
  } fcs_st_s;

endpackage

// ===== fcs_sequencer.sv
// Summary of operation
// - Read command loads addressed word into data.
// - Write command programs data, about 50 us.
// - Erase-write erases page then programs, 20 ms.
// - Verify compares word, mismatch sets status bit 1.
// - Page erase erases only the addressed page.
// - Mass erase spares kernel, takes 2.48 s.
// - Mass erase needs a preceding key write.
// - Signature builds 24-bit value in 32778 cycles.
// - Protect stores protection value once until cleared.
// - Only mass erase or key clears protection.
// - Ping does nothing but still completes.
// - Command register reads 0x07 after codes 0-6.
// - Busy bit high while a command runs.
// - Interrupt bit set on completion when enabled.
// - Erase and write need mode bit 3.
`include "fcs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module fcs_sequencer
  import fcs_pkg::*;
#(
  parameter int unsigned WRITE_CYC = (`FCS_WRITE_NS * (`FCS_CLK_HZ / 1000000)
                                      + 999) / 1000,
  parameter int unsigned ERASE_WR_CYC = `FCS_ERASE_WR_US * (`FCS_CLK_HZ
                                         / 1000000),
  parameter int unsigned MASS_CYC = `FCS_MASS_ERASE_MS * (`FCS_CLK_HZ / 1000),
  parameter int unsigned SIGN_CYC = `FCS_SIGN_CYCLES
) (
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  input  wire fcs_cmd_s    cmd_i,
  input  wire logic [7:0]  mode_i,
  input  wire logic        status_rd_i,
  input  wire logic [31:0] prot_value_i,
  input  wire logic        key_wr_i,
  input  wire logic [7:0]  key_i,
  input  wire logic [31:0] unlock_key_i,
  input  wire logic        unlock_wr_i,
  input  wire logic        arr_ack_i,
  input  wire logic [15:0] arr_rdata_i,
  output logic [3:0]       cmd_read_o,
  output logic [15:0]      data_o,
  output logic [4:0]       status_o,
  output logic [23:0]      sign_o,
  output logic [31:0]      prot_o,
  output logic             prot_locked_o,
  output fcs_array_s       arr_o
);

  fcs_st_s st;
  fcs_st_s next_st;

  function automatic logic alters(input logic [3:0] c);
    return c == `FCS_CMD_WRITE || c == `FCS_CMD_ERASE_WR ||
           c == `FCS_CMD_PAGE_ERASE || c == `FCS_CMD_MASS_ERASE;
  endfunction

  function automatic logic [31:0] op_cycles(input logic [3:0] c);
    unique case (c)
      `FCS_CMD_WRITE:      op_cycles = WRITE_CYC;
      `FCS_CMD_ERASE_WR:   op_cycles = ERASE_WR_CYC;
      `FCS_CMD_MASS_ERASE: op_cycles = MASS_CYC;
      default:             op_cycles = 32'h1;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.arr.req = 1'b0;
    if (status_rd_i) begin
      next_st.status[`FCS_STA_COMPLETE] = 1'b0;
      next_st.status[`FCS_STA_FAIL] = 1'b0;
      next_st.status[`FCS_STA_IRQ] = 1'b0;
    end
    if (key_wr_i) begin
      next_st.mass_key = key_i;
    end
    if (unlock_wr_i && unlock_key_i == st.prot) begin
      next_st.prot_locked = 1'b0;
      next_st.prot_done = 1'b0;
    end
    unique case (st.state)
      FCS_IDLE: begin
        next_st.status[`FCS_STA_BUSY] = 1'b0;
        if (cmd_i.wr_en) begin
          next_st.cmd_code = cmd_i.code;
          next_st.cmd_read = cmd_i.code;
          next_st.data = cmd_i.data;
          next_st.arr.addr = cmd_i.addr;
          next_st.arr.wdata = cmd_i.data;
          next_st.arr.write = 1'b0;
          next_st.arr.erase_page = 1'b0;
          next_st.arr.erase_mass = 1'b0;
          next_st.fail = 1'b0;
          next_st.status[`FCS_STA_BUSY] = 1'b1;
          next_st.timer = op_cycles(cmd_i.code);
          next_st.state = FCS_DONE;
          if (alters(cmd_i.code) && !mode_i[`FCS_MOD_WR_EN]) begin
            next_st.fail = 1'b1;
          end else if (cmd_i.code == `FCS_CMD_MASS_ERASE &&
                       st.mass_key != `FCS_MASS_KEY) begin
            next_st.fail = 1'b1;
          end else if (cmd_i.code == `FCS_CMD_MASS_ERASE &&
                       cmd_i.addr < 16'(`FCS_KERNEL_WORDS)) begin
            next_st.arr.addr = 16'(`FCS_KERNEL_WORDS);
            next_st.arr.erase_mass = 1'b1;
            next_st.arr.req = 1'b1;
            next_st.state = FCS_ARRAY;
          end else begin
            unique case (cmd_i.code)
              `FCS_CMD_READ, `FCS_CMD_VERIFY: begin
                next_st.arr.req = 1'b1;
                next_st.state = FCS_ARRAY;
              end
              `FCS_CMD_WRITE: begin
                next_st.arr.write = 1'b1;
                next_st.arr.req = 1'b1;
                next_st.state = FCS_ARRAY;
              end
              `FCS_CMD_ERASE_WR: begin
                next_st.arr.erase_page = 1'b1;
                next_st.arr.write = 1'b1;
                next_st.arr.req = 1'b1;
                next_st.state = FCS_ARRAY;
              end
              `FCS_CMD_PAGE_ERASE: begin
                next_st.arr.erase_page = 1'b1;
                next_st.arr.req = 1'b1;
                next_st.state = FCS_ARRAY;
              end
              `FCS_CMD_MASS_ERASE: begin
                next_st.arr.erase_mass = 1'b1;
                next_st.arr.req = 1'b1;
                next_st.state = FCS_ARRAY;
              end
              `FCS_CMD_SIGNATURE: begin
                next_st.sign = 24'h0;
                next_st.timer = SIGN_CYC - 32'h1;
                next_st.state = FCS_SIGN;
              end
              `FCS_CMD_PROTECT: begin
                if (st.prot_done) begin
                  next_st.fail = 1'b1;
                end else begin
                  next_st.prot = prot_value_i;
                  next_st.prot_locked = 1'b1;
                  next_st.prot_done = 1'b1;
                end
              end
              default: begin
                next_st.state = FCS_DONE;
              end
            endcase
          end
        end
      end
      FCS_ARRAY: begin
        next_st.arr.req = !arr_ack_i;
        if (arr_ack_i) begin
          if (st.cmd_code == `FCS_CMD_READ) begin
            next_st.data = arr_rdata_i;
          end
          if (st.cmd_code == `FCS_CMD_VERIFY) begin
            next_st.fail = arr_rdata_i != st.data;
          end
          if (st.arr.erase_mass) begin
            next_st.prot = 32'h0;
            next_st.prot_locked = 1'b0;
            next_st.prot_done = 1'b0;
            next_st.mass_key = 8'h0;
          end
          next_st.state = FCS_WAIT;
        end
      end
      FCS_WAIT: begin
        // Array timing is enforced here after the acknowledge, so software sees the handshake time plus a fixed wait.
        next_st.timer = st.timer - 32'h1;
        if (st.timer <= 32'h1) begin
          next_st.state = FCS_DONE;
        end
      end
      FCS_SIGN: begin
        next_st.sign = {st.sign[22:0], st.sign[23] ^ st.sign[22]}
                       ^ {8'h0, st.arr.addr};
        next_st.timer = st.timer - 32'h1;
        if (st.timer <= 32'h1) begin
          next_st.state = FCS_DONE;
        end
      end
      FCS_DONE: begin
        next_st.status[`FCS_STA_BUSY] = 1'b0;
        next_st.status[`FCS_STA_COMPLETE] = !st.fail;
        next_st.status[`FCS_STA_FAIL] = st.fail;
        if (mode_i[`FCS_MOD_IRQ_EN]) begin
          next_st.status[`FCS_STA_IRQ] = 1'b1;
        end
        if (st.cmd_code <= `FCS_CMD_MASS_ERASE) begin
          next_st.cmd_read = `FCS_CMD_DONE_CODE;
        end
        next_st.state = FCS_IDLE;
      end
      default: next_st.state = FCS_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
      st.state <= FCS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign cmd_read_o = st.cmd_read;
  assign data_o = st.data;
  assign status_o = st.status;
  assign sign_o = st.sign;
  assign prot_o = st.prot;
  assign prot_locked_o = st.prot_locked;
  assign arr_o = st.arr;

endmodule

`default_nettype wire

// ===== fcs_sequencer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_seq_chk
  import fcs_pkg::*;
#(
  parameter int unsigned SIGN_CYC = 32778
) (
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  input  wire fcs_cmd_s   cmd_i,
  input  wire logic [7:0] mode_i,
  input  wire logic       status_rd_i,
  input  wire logic       arr_ack_i,
  input  wire logic [3:0] cmd_read_o,
  input  wire logic [4:0] status_o,
  input  wire fcs_array_s arr_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [3:0]  code_q;
  logic [31:0] busy_n;
  // Busy time is counted here, because the signature run is too long to unroll.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      code_q <= 4'h0;
      busy_n <= 32'h0;
    end else if (cmd_i.wr_en && !status_o[2]) begin
      code_q <= cmd_i.code;
      busy_n <= 32'h0;
    end else if (status_o[2]) begin
      busy_n <= busy_n + 32'h1;
    end
  end
  sequence s_take;
    cmd_i.wr_en && !status_o[2];
  endsequence
  sequence s_end;
    $fell(status_o[2]);
  endsequence
  chk_busy_start: assert property (
    s_take ##0 (mode_i[3] && cmd_i.code inside {[4'h1:4'h5]})
    |=> status_o[2] && arr_o.req) else $error("busy or request missing");
  chk_req_hold: assert property (
    arr_o.req && !arr_ack_i |=> arr_o.req && $stable(arr_o.addr)
    && $stable(arr_o.wdata)) else $error("array request dropped early");
  chk_refuse_alter: assert property (
    s_take ##0 (!mode_i[3] && cmd_i.code inside {4'h2, 4'h3, 4'h5, 4'h6})
    |=> !arr_o.req [*3]) else $error("array altered while locked");
  chk_ping_done: assert property (
    s_take ##0 (cmd_i.code == 4'hf) |-> ##[1:3] (status_o[0] && !status_o[2]))
    else $error("ping did not complete");
  chk_done_code: assert property (
    s_end ##0 (code_q <= 4'h6 && !status_o[1]) |-> cmd_read_o == 4'h7)
    else $error("command register not 7 after command");
  // The enable is taken in the finishing cycle, one edge before complete shows.
  chk_irq_flag: assert property (
    $rose(status_o[0]) && $past(mode_i[4]) |-> status_o[3])
    else $error("interrupt flag missing");
  chk_kernel_kept: assert property (
    arr_o.req && arr_o.erase_mass |-> arr_o.addr >= 16'h0400)
    else $error("mass erase reached kernel");
  chk_read_clear: assert property (
    status_rd_i && !status_o[2] && !cmd_i.wr_en |=> (status_o & 5'h0b) == 5'h0)
    else $error("status read did not clear");
  chk_sign_len: assert property (
    s_end ##0 (code_q == 4'hb) |-> busy_n >= SIGN_CYC - 1
    && busy_n <= SIGN_CYC + 3) else $error("signature length wrong");
endmodule
bind fcs_sequencer fcs_seq_chk #(.SIGN_CYC(SIGN_CYC)) u_chk (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .cmd_i(cmd_i),
  .mode_i(mode_i), .status_rd_i(status_rd_i), .arr_ack_i(arr_ack_i),
  .cmd_read_o(cmd_read_o), .status_o(status_o), .arr_o(arr_o));
`default_nettype wire

// ===== fcs_array_model.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_array_model
  import fcs_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire fcs_array_s arr_i,
  output logic            ack_o,
  output logic [15:0]     rdata_o
);
  logic [15:0] mem [16];
  logic [1:0]  dly = 2'd0;
  initial begin
    ack_o = 1'b0;
    rdata_o = 16'h0;
    foreach (mem[i]) mem[i] = 16'h0;
  end
  // Odd addresses answer at once, even ones late, to cover both paces.
  always @(posedge sys_clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (arr_i.req && !ack_o) begin
      dly <= dly + 2'd1;
      if (dly == (arr_i.addr[0] ? 2'd0 : 2'd2)) begin
        dly <= 2'd0;
        ack_o <= 1'b1;
        rdata_o <= mem[arr_i.addr[3:0]];
        if (arr_i.erase_mass && arr_i.addr >= 16'h0400) begin
          foreach (mem[i]) mem[i] = 16'hffff;
        end
        if (arr_i.erase_page) begin
          foreach (mem[i]) mem[i] = 16'hffff;
        end
        if (arr_i.write) begin
          mem[arr_i.addr[3:0]] = arr_i.wdata;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import fcs_pkg::*;;
  localparam int unsigned SIGN = 20;
  logic sys_clk_i = 1'b0, arst_n_i = 1'b0, status_rd_i = 1'b0;
  logic key_wr_i = 1'b0, unlock_wr_i = 1'b0, arr_ack_i, prot_locked_o;
  logic [7:0]  mode_i = 8'h18, key_i = 8'h0;
  logic [31:0] prot_value_i = 32'haabbccdd, unlock_key_i = 32'h0, prot_o;
  logic [15:0] arr_rdata_i, data_o;
  logic [3:0]  cmd_read_o;
  logic [4:0]  status_o, st;
  logic [23:0] sign_o;
  fcs_cmd_s    cmd_i = '0;
  fcs_array_s  arr_o;
  int err_total = 0, samples_checked = 0, cyc = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  fcs_sequencer #(.WRITE_CYC(5), .ERASE_WR_CYC(5), .MASS_CYC(5),
    .SIGN_CYC(SIGN)) u_dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .cmd_i(cmd_i), .mode_i(mode_i), .status_rd_i(status_rd_i),
    .prot_value_i(prot_value_i), .key_wr_i(key_wr_i), .key_i(key_i),
    .unlock_key_i(unlock_key_i), .unlock_wr_i(unlock_wr_i),
    .arr_ack_i(arr_ack_i), .arr_rdata_i(arr_rdata_i),
    .cmd_read_o(cmd_read_o), .data_o(data_o), .status_o(status_o),
    .sign_o(sign_o), .prot_o(prot_o), .prot_locked_o(prot_locked_o),
    .arr_o(arr_o));
  fcs_array_model u_arr (.sys_clk_i(sys_clk_i), .arr_i(arr_o),
    .ack_o(arr_ack_i), .rdata_o(arr_rdata_i));
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string n, input logic [31:0] e, s);
    samples_checked++;
    if (e !== s) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Status is cleared after every command so stale flags never hide a miss.
  task automatic run(input logic [3:0] c, input logic [15:0] a, d);
    int n;
    @(posedge sys_clk_i);
    cmd_i <= fcs_cmd_s'{1'b1, c, a, d};
    @(posedge sys_clk_i);
    cmd_i.wr_en <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end while ((status_o[2] !== 1'b0 || status_o[1:0] === 2'b00) && n < 60);
    cmp("run_limit", 1'b0, n >= 60);
    st = status_o;
    @(posedge sys_clk_i);
    status_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    status_rd_i <= 1'b0;
    #1 cmp("status_clear", 5'h0, status_o & 5'h0b);
  endtask
  task automatic rd(input logic [15:0] a, e);
    run(4'h1, a, 16'h0);
    cmp("read_data", e, data_o);
  endtask
  task automatic put_key(input logic unl, input logic [31:0] k);
    @(posedge sys_clk_i);
    key_wr_i <= !unl;
    unlock_wr_i <= unl;
    key_i <= k[7:0];
    unlock_key_i <= k;
    @(posedge sys_clk_i);
    key_wr_i <= 1'b0;
    unlock_wr_i <= 1'b0;
    // Wait past the edge that takes the key so its effect is visible.
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    run(4'h2, 16'h0003, 16'h1234);
    cmp("write_status", 5'h09, st);
    rd(16'h0003, 16'h1234);
    cmp("cmd_read", 4'h7, cmd_read_o);
    run(4'h4, 16'h0003, 16'h1234);
    cmp("verify_ok", 2'b01, st[1:0]);
    run(4'h4, 16'h0003, 16'h4321);
    cmp("verify_bad", 2'b10, st[1:0]);
    run(4'h5, 16'h0002, 16'h5555);
    rd(16'h0003, 16'hffff);
    run(4'h3, 16'h0005, 16'habcd);
    rd(16'h0005, 16'habcd);
    @(posedge sys_clk_i);
    mode_i <= 8'h10;
    run(4'h2, 16'h0005, 16'h0000);
    cmp("locked_write", 2'b10, st[1:0]);
    rd(16'h0005, 16'habcd);
    @(posedge sys_clk_i);
    mode_i <= 8'h18;
    run(4'h6, 16'h0000, 16'h0000);
    cmp("mass_nokey", 2'b10, st[1:0]);
    put_key(1'b0, 32'h3c);
    run(4'h6, 16'h0000, 16'h0000);
    cmp("mass_status", 2'b01, st[1:0]);
    rd(16'h0005, 16'hffff);
    run(4'hb, 16'h0001, 16'h0000);
    cmp("sign_status", 2'b01, st[1:0]);
    cmp("sign_value", 1'b1, |sign_o);
    run(4'hc, 16'h0000, 16'h0000);
    cmp("prot_value", 32'haabbccdd, prot_o);
    cmp("prot_lock", 1'b1, prot_locked_o);
    @(posedge sys_clk_i);
    prot_value_i <= 32'h11111111;
    run(4'hc, 16'h0000, 16'h0000);
    cmp("prot_fail", 2'b10, st[1:0]);
    cmp("prot_again", 32'haabbccdd, prot_o);
    run(4'h5, 16'h0002, 16'h0000);
    put_key(1'b1, 32'h12345678);
    cmp("prot_kept", 1'b1, prot_locked_o);
    put_key(1'b1, 32'haabbccdd);
    cmp("prot_unlock", 1'b0, prot_locked_o);
    run(4'hc, 16'h0000, 16'h0000);
    cmp("prot_relock", 1'b1, prot_locked_o);
    put_key(1'b0, 32'h3c);
    run(4'h6, 16'h0000, 16'h0000);
    cmp("prot_mass", 1'b0, prot_locked_o);
    cmp("prot_mass_val", 32'h0, prot_o);
    run(4'h9, 16'h0005, 16'h0000);
    cmp("reserved_st", 5'h09, st);
    rd(16'h0005, 16'hffff);
    run(4'hf, 16'h0000, 16'h0000);
    cmp("ping_irq", 5'h09, st);
    cmp("cmd_read_ping", 4'hf, cmd_read_o);
    @(posedge sys_clk_i);
    mode_i <= 8'h08;
    run(4'hf, 16'h0000, 16'h0000);
    cmp("ping_noirq", 5'h01, st);
    tally_and_finish();
  end
endmodule
`default_nettype wire
